// ==== design/ccis_dev.sv ====
// Purpose: Device end of the two-wire slave port of a coulomb counter
// Assumes: Link clock oversamples the bus; core side holds registers
// Notes:   Commands are handed to the core side; commit follows STOP
`timescale 1ns/1ps
module ccis_dev (
    input  wire logic               i_core_clk,
    input  wire logic               i_resetn,
    input  wire logic               i_link_clk,
    input  wire logic               i_interface_supply_ok,
    ccis_if.dev                     bus,
    output      logic               o_ptr_valid,
    output      ccis_pkg::ccis_byte_t o_ptr,
    output      logic               o_wr_valid,
    output      ccis_pkg::ccis_byte_t o_wr_addr,
    output      ccis_pkg::ccis_byte_t o_wr_data,
    output      logic               o_commit,
    input  wire ccis_pkg::ccis_byte_t i_rd_data
);
    import ccis_pkg::*;

    // ==========================================================
    // Link side: synchronisers and glitch filter
    logic [2:0] raw_s1_q;
    logic [2:0] raw_s2_q;
    logic [1:0] filt;
    logic       scl_p_q;
    logic       sda_p_q;
    logic       scl;
    logic       sda;
    logic       sup_ok;

    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            raw_s1_q <= 3'h7;
            raw_s2_q <= 3'h7;
        end else begin
            raw_s1_q <= {i_interface_supply_ok, bus.sda, bus.scl};
            raw_s2_q <= raw_s1_q;
        end
    end

    genvar g;
    for (g = 0; g < 2; g = g + 1) begin : g_flt
        logic [1:0] cnt_q;
        logic       lvl_q;
        always_ff @(posedge i_link_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                cnt_q <= 2'h0;
                lvl_q <= 1'b1;
            end else if (raw_s2_q[g] == lvl_q) begin
                cnt_q <= 2'h0;
            end else if (cnt_q == CCIS_FLT_LAST) begin
                cnt_q <= 2'h0;
                lvl_q <= raw_s2_q[g];
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
        assign filt[g] = lvl_q;
    end

    assign scl    = filt[0];
    assign sda    = filt[1];
    assign sup_ok = raw_s2_q[2];

    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    // edges on filtered lines; start and stop are data edges with clock high
    assign scl_rise = scl & ~scl_p_q;
    assign scl_fall = ~scl & scl_p_q;
    assign start    = sup_ok & scl & scl_p_q & sda_p_q & ~sda;
    assign stop     = sup_ok & scl & scl_p_q & ~sda_p_q & sda;

    // ==========================================================
    // Link side: frame state machine
    ccis_dst_e  st_q;
    logic [3:0] cnt_q;
    ccis_byte_t sh_q;
    logic       rd_q;
    logic       oe_q;
    ccis_byte_t rd_l_q;
    logic       live;
    logic       byte_end;
    logic       addr_hit;
    logic       rx_done;

    assign live     = sup_ok & ~start & ~stop;
    assign byte_end = live & scl_fall & (cnt_q == CCIS_BYTE_BITS);
    assign addr_hit = byte_end & (st_q == CCIS_D_ADDR)
                    & (sh_q[7:1] == CCIS_ADDR7);
    assign rx_done  = byte_end & (st_q == CCIS_D_RX);

    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q  <= CCIS_D_IDLE;
            cnt_q <= 4'h0;
            sh_q  <= CCIS_BYTE_RST;
            rd_q  <= 1'b0;
            oe_q  <= 1'b0;
        end else if (!sup_ok) begin
            st_q <= CCIS_D_IDLE;
            oe_q <= 1'b0;
        end else if (start) begin
            st_q  <= CCIS_D_ADDR;
            cnt_q <= 4'h0;
            oe_q  <= 1'b0;
        end else if (stop) begin
            st_q <= CCIS_D_IDLE;
            oe_q <= 1'b0;
        end else begin
            case (st_q)
                CCIS_D_ADDR, CCIS_D_RX: begin
                    if (scl_rise && cnt_q != CCIS_BYTE_BITS) begin
                        sh_q  <= {sh_q[6:0], sda};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_end) begin
                        cnt_q <= 4'h0;
                        if (st_q == CCIS_D_RX) begin
                            st_q <= CCIS_D_RACK;
                            oe_q <= 1'b1;
                        end else if (addr_hit) begin
                            st_q <= CCIS_D_AACK;
                            rd_q <= sh_q[0];
                            oe_q <= 1'b1;
                        end else begin
                            st_q <= CCIS_D_IDLE;
                        end
                    end
                end
                CCIS_D_AACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rd_q) begin
                            st_q <= CCIS_D_TX;
                            sh_q <= rd_l_q;
                            oe_q <= ~rd_l_q[7];
                        end else begin
                            st_q <= CCIS_D_RX;
                            oe_q <= 1'b0;
                        end
                    end
                end
                CCIS_D_RACK: begin
                    if (scl_fall) begin
                        st_q <= CCIS_D_RX;
                        oe_q <= 1'b0;
                    end
                end
                CCIS_D_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == CCIS_BYTE_BITS - 4'h1) begin
                            // further bits read high, no ack
                            st_q <= CCIS_D_IDLE;
                            oe_q <= 1'b0;
                        end else begin
                            sh_q  <= {sh_q[6:0], 1'b0};
                            oe_q  <= ~sh_q[6];
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                default: begin
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    // only the data line is ever pulled
    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = oe_q;

    // ==========================================================
    // Link side: pointer, pending data, commit and read request
    logic       sub_q;
    logic       dirty_q;
    ccis_byte_t ptr_l_q;
    ccis_byte_t wa_l_q;
    ccis_byte_t wd_l_q;
    logic [3:0] ev_t_q;
    logic [2:0] rk_q;

    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sub_q   <= 1'b1;
            dirty_q <= 1'b0;
            ptr_l_q <= CCIS_BYTE_RST;
            wa_l_q  <= CCIS_BYTE_RST;
            wd_l_q  <= CCIS_BYTE_RST;
            ev_t_q  <= 4'h0;
        end else begin
            if (addr_hit) begin
                sub_q <= 1'b1;
                // fetch read byte on read address
                if (sh_q[0]) begin
                    ev_t_q[3] <= ~ev_t_q[3];
                end
            end else if (rx_done) begin
                // odd bytes pointer, even bytes data
                sub_q <= ~sub_q;
                if (sub_q) begin
                    ptr_l_q   <= sh_q;
                    ev_t_q[0] <= ~ev_t_q[0];
                end else begin
                    wa_l_q    <= ptr_l_q;
                    wd_l_q    <= sh_q;
                    dirty_q   <= 1'b1;
                    ev_t_q[1] <= ~ev_t_q[1];
                end
            end else if (stop && dirty_q) begin
                dirty_q   <= 1'b0;
                ev_t_q[2] <= ~ev_t_q[2];
            end
        end
    end

    // Read word arrives by toggle handshake from the core side
    ccis_byte_t rd_hold_q;
    logic       rk_t_q;

    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rk_q   <= 3'h0;
            rd_l_q <= CCIS_BYTE_RST;
        end else begin
            rk_q <= {rk_q[1:0], rk_t_q};
            if (rk_q[2] != rk_q[1]) begin
                rd_l_q <= rd_hold_q;
            end
        end
    end

    // ==========================================================
    // Core side: event crossings
    logic [3:0] ev_p;

    for (g = 0; g < 4; g = g + 1) begin : g_ev
        logic [2:0] s_q;
        always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                s_q <= 3'h0;
            end else begin
                s_q <= {s_q[1:0], ev_t_q[g]};
            end
        end
        assign ev_p[g] = s_q[2] ^ s_q[1];
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ptr_valid <= 1'b0;
            o_ptr       <= CCIS_BYTE_RST;
            o_wr_valid  <= 1'b0;
            o_wr_addr   <= CCIS_BYTE_RST;
            o_wr_data   <= CCIS_BYTE_RST;
            o_commit    <= 1'b0;
        end else begin
            o_ptr_valid <= ev_p[0];
            o_wr_valid  <= ev_p[1];
            o_commit    <= ev_p[2];
            if (ev_p[0]) begin
                o_ptr <= ptr_l_q;
            end
            if (ev_p[1]) begin
                o_wr_addr <= wa_l_q;
                o_wr_data <= wd_l_q;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_hold_q <= CCIS_BYTE_RST;
            rk_t_q    <= 1'b0;
        end else if (ev_p[3]) begin
            rd_hold_q <= i_rd_data;
            rk_t_q    <= ~rk_t_q;
        end
    end

endmodule // ccis_dev

// ==== design/ccis_host.sv ====
// Purpose: Bus master end: writes pointer and data, reads one byte
// Assumes: Core clock makes the serial clock by division
// Notes:   Clock line is only ever pulled low or released
`timescale 1ns/1ps
module ccis_host (
    input  wire logic               i_core_clk,
    input  wire logic               i_resetn,
    ccis_if.host                    bus,
    input  wire logic               i_cmd_valid,
    output      logic               o_cmd_ready,
    input  wire logic               i_cmd_read,
    input  wire ccis_pkg::ccis_byte_t i_cmd_ptr,
    input  wire ccis_pkg::ccis_byte_t i_cmd_data,
    input  wire logic               i_cmd_data_en,
    output      logic               o_rsp_valid,
    output      ccis_pkg::ccis_byte_t o_rsp_data,
    output      logic               o_rsp_nack
);
    import ccis_pkg::*;

    // ==========================================================
    // Quarter-period tick
    ccis_hst_e  st_q;
    logic [6:0] qc_q;
    logic       tick;
    logic       sda_s1_q;
    logic       sda_s2_q;

    assign tick        = (st_q != CCIS_H_IDLE) & (qc_q == CCIS_QTR_LAST);
    assign o_cmd_ready = (st_q == CCIS_H_IDLE);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            qc_q <= 7'h0;
        end else if (st_q == CCIS_H_IDLE || tick) begin
            qc_q <= 7'h0;
        end else begin
            qc_q <= qc_q + 7'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= bus.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    // ==========================================================
    // Transaction sequencer
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [1:0] last_q;
    logic       rd_q;
    ccis_byte_t ptr_q;
    ccis_byte_t dat_q;
    ccis_byte_t sh_q;
    logic       scl_lo_q;
    logic       sda_lo_q;
    logic       nack_q;
    logic       rx_byte;

    assign rx_byte = rd_q & (byte_q == 2'h1);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q        <= CCIS_H_IDLE;
            ph_q        <= 2'h0;
            bit_q       <= 4'h0;
            byte_q      <= 2'h0;
            last_q      <= 2'h0;
            rd_q        <= 1'b0;
            ptr_q       <= CCIS_BYTE_RST;
            dat_q       <= CCIS_BYTE_RST;
            sh_q        <= CCIS_BYTE_RST;
            scl_lo_q    <= 1'b0;
            sda_lo_q    <= 1'b0;
            nack_q      <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_data  <= CCIS_BYTE_RST;
            o_rsp_nack  <= 1'b0;
        end else begin
            o_rsp_valid <= 1'b0;
            if (tick) begin
                ph_q <= ph_q + 2'h1;
            end
            case (st_q)
                CCIS_H_IDLE: begin
                    if (i_cmd_valid) begin
                        st_q   <= CCIS_H_STA;
                        ph_q   <= 2'h0;
                        rd_q   <= i_cmd_read;
                        ptr_q  <= i_cmd_ptr;
                        dat_q  <= i_cmd_data;
                        last_q <= (!i_cmd_read && i_cmd_data_en) ?
                                  2'h2 : 2'h1;
                        nack_q <= 1'b0;
                    end
                end
                CCIS_H_STA: begin
                    if (tick && ph_q == 2'h1) begin
                        sda_lo_q <= 1'b1;
                    end else if (tick && ph_q == 2'h2) begin
                        scl_lo_q <= 1'b1;
                    end else if (tick && ph_q == 2'h3) begin
                        st_q   <= CCIS_H_BYTE;
                        bit_q  <= 4'h0;
                        byte_q <= 2'h0;
                        sh_q   <= rd_q ? CCIS_RD_ADDR : CCIS_WR_ADDR;
                    end
                end
                CCIS_H_BYTE: begin
                    if (tick) begin
                        case (ph_q)
                            2'h0: begin
                                // release on ack slot of sent byte
                                sda_lo_q <= !rx_byte
                                    && bit_q != CCIS_BYTE_BITS
                                    && !sh_q[7];
                            end
                            2'h1: begin
                                scl_lo_q <= 1'b0;
                            end
                            2'h2: begin
                                if (rx_byte && bit_q != CCIS_BYTE_BITS) begin
                                    o_rsp_data <= {o_rsp_data[6:0], sda_s2_q};
                                end
                                if (!rx_byte && bit_q == CCIS_BYTE_BITS) begin
                                    nack_q <= sda_s2_q;
                                end
                            end
                            default: begin
                                scl_lo_q <= 1'b1;
                                if (bit_q == CCIS_BYTE_BITS) begin
                                    bit_q <= 4'h0;
                                    if (nack_q || byte_q == last_q) begin
                                        st_q <= CCIS_H_STO;
                                    end else begin
                                        byte_q <= byte_q + 2'h1;
                                        sh_q   <= (byte_q == 2'h0) ?
                                                  ptr_q : dat_q;
                                    end
                                end else begin
                                    bit_q <= bit_q + 4'h1;
                                    sh_q  <= {sh_q[6:0], 1'b0};
                                end
                            end
                        endcase
                    end
                end
                default: begin
                    if (tick && ph_q == 2'h0) begin
                        sda_lo_q <= 1'b1;
                    end else if (tick && ph_q == 2'h1) begin
                        scl_lo_q <= 1'b0;
                    end else if (tick && ph_q == 2'h2) begin
                        sda_lo_q <= 1'b0;
                    end else if (tick) begin
                        st_q        <= CCIS_H_IDLE;
                        o_rsp_valid <= 1'b1;
                        o_rsp_nack  <= nack_q;
                    end
                end
            endcase
        end
    end

    assign bus.scl_m_o  = 1'b0;
    assign bus.scl_m_oe = scl_lo_q;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = sda_lo_q;

endmodule // ccis_host

// ==== design/ccis_if.sv ====
// Purpose: Open-drain two-wire bus joining master end and device end
// Assumes: External pull-ups; a line is low when any party enables low
// Notes:   The device has no clock output at all
`timescale 1ns/1ps
interface ccis_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // ==========================================================
    // Wired-AND resolution with pull-ups
    assign scl = scl_m_oe ? scl_m_o : 1'b1;
    assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

    modport host (
        output scl_m_o,
        output scl_m_oe,
        output sda_m_o,
        output sda_m_oe,
        input  scl,
        input  sda
    );

    modport dev (
        output sda_s_o,
        output sda_s_oe,
        input  scl,
        input  sda
    );
endinterface

// ==== design/ccis_pkg.sv ====
// Purpose: Shared constants and types for the two-wire serial slave port
// Assumes: Core clock 100 MHz, serial clock at most 400 kHz
// Notes:   Used by the device end, the master end and the testbench
package ccis_pkg;

    // ==========================================================
    // Types
    typedef logic [7:0] ccis_byte_t;

    typedef enum logic [5:0] {
        CCIS_D_IDLE = 6'h01,
        CCIS_D_ADDR = 6'h02,
        CCIS_D_AACK = 6'h04,
        CCIS_D_RX   = 6'h08,
        CCIS_D_RACK = 6'h10,
        CCIS_D_TX   = 6'h20
    } ccis_dst_e;

    typedef enum logic [3:0] {
        CCIS_H_IDLE = 4'h1,
        CCIS_H_STA  = 4'h2,
        CCIS_H_BYTE = 4'h4,
        CCIS_H_STO  = 4'h8
    } ccis_hst_e;

    // ==========================================================
    // Addressing and framing
    localparam logic [6:0] CCIS_ADDR7     = 7'h64;
    localparam logic [7:0] CCIS_WR_ADDR   = {CCIS_ADDR7, 1'b0};
    localparam logic [7:0] CCIS_RD_ADDR   = {CCIS_ADDR7, 1'b1};
    localparam logic [3:0] CCIS_BYTE_BITS = 4'h8;
    localparam logic [7:0] CCIS_BYTE_RST  = 8'h00;

    // ==========================================================
    // Timing
    localparam int         CCIS_CORE_MHZ  = 100;
    localparam int         CCIS_SCL_KHZ   = 400;
    // Quarter of the serial clock period, rounded up (keeps rate <= max)
    localparam int         CCIS_QTR_CYC   =
        (CCIS_CORE_MHZ * 1000 + 4 * CCIS_SCL_KHZ - 1) / (4 * CCIS_SCL_KHZ);
    localparam logic [6:0] CCIS_QTR_LAST  = 7'(CCIS_QTR_CYC - 1);
    // Glitch filter: input must differ for this many link clocks plus one
    localparam logic [1:0] CCIS_FLT_LAST  = 2'h2;

endpackage

// ==== verif/ccis_chk.sv ====
// Purpose: Checks on the two-wire link between host and device ends
// Assumes: Core clock far faster than the serial clock
// Notes:   Frame position is tracked from the resolved lines
`timescale 1ns/1ps
module ccis_chk (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_interface_supply_ok,
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q;
    logic       sda_q;
    logic       rd_q;
    logic [3:0] cnt_q;
    logic [1:0] frm_q;
    logic       hi;
    logic       ack_hi;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    // ==========================================================
    // Frame position: rises 1 to 8 data, 9 acknowledge
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= 4'h0;
            frm_q <= 2'h0;
            rd_q  <= 1'b0;
        end else if (scl && sda_q && !sda) begin
            cnt_q <= 4'h0;
            frm_q <= 2'h0;
            rd_q  <= 1'b0;
        end else if (scl && !scl_q) begin
            cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
            if (cnt_q == 4'h9 && frm_q != 2'h3) begin
                frm_q <= frm_q + 2'h1;
            end
            if (cnt_q == 4'h7 && frm_q == 2'h0) begin
                rd_q <= sda;
            end
        end
    end

    assign hi     = scl && scl_q;
    assign ack_hi = hi && cnt_q == 4'h9;

    // ==========================================================
    // Assertions
    scl_host_only_a: assert property (scl == !scl_m_oe)
        else $error("clock line not set by host alone");
    clk_low_len_a: assert property (
        $rose(scl_m_oe) |-> ##119 scl_m_oe ##[1:140] $fell(scl_m_oe))
        else $error("clock low phase length wrong");
    bus_contend_a: assert property (hi && sda_s_oe |-> !sda_m_oe)
        else $error("both ends drive data");
    dev_edge_a: assert property ($rose(sda_s_oe) |-> !scl)
        else $error("device changed data with clock high");
    addr_ack_a: assert property (
        ack_hi && frm_q == 2'h0 && i_interface_supply_ok |-> sda_s_oe)
        else $error("address not acknowledged");
    wr_ack_a: assert property (
        ack_hi && !rd_q && i_interface_supply_ok |-> sda_s_oe)
        else $error("written byte not acknowledged");
    host_rel_a: assert property (ack_hi |-> !sda_m_oe)
        else $error("host holds data in acknowledge");
    rd_noack_a: assert property (
        ack_hi && rd_q && frm_q == 2'h1 |-> !sda_s_oe)
        else $error("device acknowledged in read");
    rd_roles_a: assert property (
        hi && !ack_hi && rd_q && frm_q == 2'h1 |-> !sda_m_oe)
        else $error("host drives data during read byte");
endmodule // ccis_chk

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the host and device ends together
// Assumes: Core clock 10 ns, link clock 48 ns, unrelated phase
// Notes:   Random writes, pointer reads and a supply lockout
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("Error at %0t: got %h, expected %h", $time, got, exp); \
    end \
end
module testbench;
    import ccis_pkg::*;
    logic       i_core_clk;
    logic       i_link_clk;
    logic       i_resetn;
    logic       supply_ok;
    logic       cmd_valid;
    logic       cmd_ready;
    logic       cmd_read;
    logic       cmd_den;
    logic       rsp_valid;
    logic       rsp_nack;
    logic       ptr_valid;
    logic       wr_valid;
    logic       commit;
    ccis_byte_t cmd_ptr;
    ccis_byte_t cmd_data;
    ccis_byte_t rsp_data;
    ccis_byte_t ptr;
    ccis_byte_t wr_addr;
    ccis_byte_t wr_data;
    ccis_byte_t e_ptr;
    ccis_byte_t e_dat;
    logic [7:0] fb;
    int         nb, seed, errors, checks_done, nptr, nwr, ncom;

    function automatic ccis_byte_t exp_rd(input ccis_byte_t p);
        return {p[3:0], p[7:4]} ^ 8'h3c;
    endfunction

    ccis_if ccis_if_i ();
    ccis_host ccis_host_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .bus(ccis_if_i), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
        .i_cmd_read(cmd_read), .i_cmd_ptr(cmd_ptr), .i_cmd_data(cmd_data),
        .i_cmd_data_en(cmd_den), .o_rsp_valid(rsp_valid),
        .o_rsp_data(rsp_data), .o_rsp_nack(rsp_nack));
    ccis_dev ccis_dev_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .i_link_clk(i_link_clk), .i_interface_supply_ok(supply_ok),
        .bus(ccis_if_i), .o_ptr_valid(ptr_valid), .o_ptr(ptr),
        .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
        .o_commit(commit), .i_rd_data(exp_rd(ptr)));
    ccis_chk ccis_chk_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .i_interface_supply_ok(supply_ok), .scl_m_oe(ccis_if_i.scl_m_oe),
        .sda_m_oe(ccis_if_i.sda_m_oe), .sda_s_oe(ccis_if_i.sda_s_oe),
        .scl(ccis_if_i.scl), .sda(ccis_if_i.sda));

    // ==========================================================
    // Clocks, device user side and wire monitor
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    initial begin
        i_link_clk = 1'b0;
        #7;
        forever #24 i_link_clk = ~i_link_clk;
    end
    always @(posedge i_core_clk) begin
        if (ptr_valid === 1'b1) begin
            nptr++;
            `CHK(ptr, e_ptr)
        end
        if (wr_valid === 1'b1) begin
            nwr++;
            `CHK({wr_addr, wr_data}, {e_ptr, e_dat})
        end
        if (commit === 1'b1) begin
            ncom++;
        end
    end
    always @(negedge ccis_if_i.sda) begin
        if (ccis_if_i.scl === 1'b1) begin
            nb = 0;
        end
    end
    always @(posedge ccis_if_i.scl) begin
        if (nb < 8) begin
            fb = {fb[6:0], ccis_if_i.sda};
            nb++;
        end
    end

    // ==========================================================
    // Transfer tasks
    task automatic xfer(input logic rd, input ccis_byte_t p, d,
                        input logic den);
        int n;
        n = 0;
        @(negedge i_core_clk);
        cmd_read  = rd;
        cmd_ptr   = p;
        cmd_data  = d;
        cmd_den   = den;
        cmd_valid = 1'b1;
        `CHK(cmd_ready, 1'b1)
        @(negedge i_core_clk);
        cmd_valid = 1'b0;
        `CHK(cmd_ready, 1'b0)
        while (rsp_valid !== 1'b1 && n < 9000) begin
            @(posedge i_core_clk);
            n++;
        end
        if (n >= 9000) begin
            errors++;
            $display("Error at %0t: no response from host", $time);
        end
        repeat (100) @(posedge i_core_clk);
        `CHK(fb, rd ? CCIS_RD_ADDR : CCIS_WR_ADDR)
        `CHK({ccis_if_i.scl, ccis_if_i.sda}, 2'h3)
    endtask

    task automatic wr(input ccis_byte_t p, d, input logic den);
        int c0, p0, w0;
        c0    = ncom;
        p0    = nptr;
        w0    = nwr;
        e_ptr = p;
        e_dat = d;
        xfer(1'b0, p, d, den);
        `CHK(rsp_nack, !supply_ok)
        `CHK(nptr - p0, supply_ok ? 1 : 0)
        `CHK(nwr - w0, (supply_ok && den) ? 1 : 0)
        `CHK(ncom - c0, (supply_ok && den) ? 1 : 0)
    endtask

    task automatic rd(input ccis_byte_t p);
        xfer(1'b1, p, 8'h00, 1'b0);
        `CHK(rsp_data, exp_rd(p))
        `CHK(rsp_nack, 1'b0)
    endtask

    task automatic test_done();
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge i_core_clk);
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        ccis_byte_t p;
        ccis_byte_t d;
        seed      = 9853;
        nb        = 8;
        i_resetn  = 1'b0;
        supply_ok = 1'b1;
        cmd_valid = 1'b0;
        cmd_read  = 1'b0;
        cmd_den   = 1'b0;
        cmd_ptr   = 8'h00;
        cmd_data  = 8'h00;
        repeat (3) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_resetn = 1'b1;
        repeat (20) @(posedge i_core_clk);
        for (int i = 0; i < 4; i++) begin
            p = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            d = (i < 2) ? ~p : 8'($random(seed));
            wr(p, d, 1'b1);
        end
        p = 8'($random(seed));
        wr(p, 8'h00, 1'b0);
        rd(p);
        rd(p);
        @(negedge i_core_clk);
        supply_ok = 1'b0;
        wr(8'h5a, 8'ha5, 1'b1);
        @(negedge i_core_clk);
        supply_ok = 1'b1;
        wr(8'h3c, 8'hc3, 1'b1);
        test_done();
    end
endmodule // testbench
